//--- lpdcc_pkg.sv
// Timing constants and codes for the power-down and clock-change sequencer.
// Assumes a 100 MHz system clock; the memory clock is divided from it.
package lpdcc_pkg;

	localparam int SYS_PERIOD_PS = 10000;
	localparam int TW            = 16;

	// Analogue parts of the combined delays, in ps
	localparam int T_CMDCKE_PS  = 1750;
	localparam int T_CKE_PS     = 7500;
	localparam int T_CKELCK_PS  = 5000;
	localparam int T_CKELCS_PS  = 5000;
	localparam int T_CSCKE_PS   = 1750;
	localparam int T_CKCKEH_PS  = 1750;
	localparam int T_CSCKEH_PS  = 1750;
	localparam int T_XP_PS      = 7500;
	localparam int T_CKEHCS_PS  = 7500;
	localparam int T_MRWCKEL_PS = 14000;
	localparam int T_ZQCKE_PS   = 1750;
	// Worst read strobe skew; plain default, not a part figure
	localparam int T_DQSCK_PS   = 3500;

	// Rounded up to whole system cycles
	localparam logic [TW-1:0] CYC_CMDCKE  =
		TW'((T_CMDCKE_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_CKE     =
		TW'((T_CKE_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_CKELCK  =
		TW'((T_CKELCK_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_CKELCS  =
		TW'((T_CKELCS_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_CSCKE   =
		TW'((T_CSCKE_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_CKCKEH  =
		TW'((T_CKCKEH_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_CSCKEH  =
		TW'((T_CSCKEH_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_XP      =
		TW'((T_XP_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_CKEHCS  =
		TW'((T_CKEHCS_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_MRWCKEL =
		TW'((T_MRWCKEL_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_ZQCKE   =
		TW'((T_ZQCKE_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
	localparam logic [TW-1:0] CYC_DQSCK   =
		TW'((T_DQSCK_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);

	// Clock-count parts, in memory clock cycles
	localparam logic [3:0] N_CMDCKE  = 4'h3;
	localparam logic [3:0] N_CKE     = 4'h4;
	localparam logic [3:0] N_CKELCK  = 4'h5;
	localparam logic [3:0] N_CKELCS  = 4'h5;
	localparam logic [3:0] N_CKCKEH  = 4'h3;
	localparam logic [3:0] N_XP      = 4'h5;
	localparam logic [3:0] N_CKEHCS  = 4'h5;
	localparam logic [3:0] N_MRWCKEL = 4'ha;
	localparam logic [3:0] N_ZQCKE   = 4'h3;
	localparam logic [3:0] N_FREQ_CK = 4'h2;
	localparam logic [7:0] POST_SHORT = 8'h01;
	localparam logic [7:0] POST_LONG  = 8'h02;

	localparam logic [7:0] HALF_DIV_RESET = 8'h04;
	localparam logic [7:0] HALF_DIV_MIN   = 8'h01;

	typedef enum logic [2:0] {
		LPDCC_CMD_REF = 3'h0,
		LPDCC_CMD_ACT = 3'h1,
		LPDCC_CMD_PRE = 3'h2,
		LPDCC_CMD_MRR = 3'h3,
		LPDCC_CMD_MRW = 3'h4,
		LPDCC_CMD_ZQ  = 3'h5,
		LPDCC_CMD_RD  = 3'h6,
		LPDCC_CMD_WR  = 3'h7
	} lpdcc_cmd_t;

	typedef enum logic [7:0] {
		ST_ACTIVE   = 8'h01,
		ST_CS_SETUP = 8'h02,
		ST_PD_HOLD  = 8'h04,
		ST_PD_IDLE  = 8'h08,
		ST_PD_WAKE  = 8'h10,
		ST_EXIT     = 8'h20,
		ST_FREQ_HI  = 8'h40
	} lpdcc_state_t;

endpackage

//--- lpdcc_timer.sv
// Down-counting delay timer that keeps the longest of overlapping loads.
// Assumes loads come from logic on the same clock.
`timescale 1ns/1ps
module lpdcc_timer
	import lpdcc_pkg::*;
(
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          rst_n,
	// Load
	input  wire logic          load,
	input  wire logic [TW-1:0] count,
	// Status
	output logic               done
);

	logic [TW-1:0] remaining;

	// Longer demand wins so no pending wait is cut short
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			remaining <= '0;
		end else if (load && count > remaining) begin
			remaining <= count;
		end else if (remaining != '0) begin
			remaining <= remaining - TW'(1);
		end
	end

	assign done = (remaining == '0);

endmodule

//--- lpdcc_ctrl.sv
// Host-side power-down and clock-change sequencer for a low-power DRAM.
// Assumes requests arrive on the system clock; it makes the memory clock.
`timescale 1ns/1ps

// How it works
// - No CKE fall while burst or MR busy
// - Refresh/activate/precharge guard before CKE falls
// - Mode read guard: latency, burst, skew, postamble
// - Mode write guard before CKE falls
// - Longer settling after mode write also waited
// - ZQ start guard; calibration continues in power-down
// - CKE high and low pulses minimum width
// - CS low before and after CKE falls
// - Clock kept running after CKE falls
// - Stable clock before CKE rises
// - CS valid before and after CKE rises
// - No command until exit latency passes
// - Delay expires only when time and clocks pass
// - Low-CKE frequency change only with banks settled
// - Old frequency kept, new clock settled first
// - Requested clock stop only with CKE low; a high-CKE change stops it one cycle
// - High-CKE change only after all commands done
// - CS low during high-CKE frequency change
// - Wait two clocks plus exit latency after
// - Flag mode rewrites after a frequency change
module lpdcc_ctrl
	import lpdcc_pkg::*;
(
	// System clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Command reports from the command scheduler
	input  wire logic       cmdValid,
	input  wire logic [2:0] cmdKind,
	input  wire logic [TW-1:0] mrwSettleCycles,
	input  wire logic [5:0] readLatency,
	input  wire logic [5:0] burstHalf,
	input  wire logic       readPostambleLengthSelect,
	input  wire logic       burstActive,
	input  wire logic       bankTimingMet,
	// Power and clock requests
	input  wire logic       pdEnterReq,
	input  wire logic       pdExitReq,
	input  wire logic       clkStopReq,
	input  wire logic       freqChangeReq,
	input  wire logic [7:0] newHalfDiv,
	// Memory pins
	output logic            ck,
	output logic            cke,
	output logic            csForceLow,
	// Status to the scheduler
	output logic            cmdAllowed,
	output logic            pdActive,
	output logic            clkStopped,
	output logic            reprogramNeeded
);

	lpdcc_state_t state;
	lpdcc_state_t next_state;

	logic [7:0]    halfDiv;
	logic [7:0]    divCount;
	logic          ckRun;
	logic          enterPending;
	logic          exitPending;
	logic          freqPending;
	logic          guardDone;
	logic          widthDone;
	logic          phaseDone;
	logic          guardLoad;
	logic [TW-1:0] guardCount;
	logic          widthLoad;
	logic          phaseLoad;
	logic [TW-1:0] phaseCount;
	logic [7:0]    safeNewDiv;

	// Combined delay in system cycles from ps and memory clocks
	function automatic logic [TW-1:0] delayCycles(
		input logic [TW-1:0] timeCycles,
		input logic [7:0]    nck,
		input logic [7:0]    half
	);
		logic [TW-1:0] clockCycles;
		clockCycles = TW'({8'h00, nck} * {8'h00, half} * 16'h0002);
		delayCycles = (timeCycles > clockCycles) ? timeCycles : clockCycles;
	endfunction

	// Zero divide would wrap the clock to 256-cycle half periods
	assign safeNewDiv = (newHalfDiv < HALF_DIV_MIN) ? HALF_DIV_MIN
		: newHalfDiv;

	// Guard load per command kind
	always_comb begin
		guardLoad  = cmdValid;
		guardCount = '0;
		case (cmdKind)
		LPDCC_CMD_REF, LPDCC_CMD_ACT, LPDCC_CMD_PRE: begin
			guardCount = delayCycles(CYC_CMDCKE, 8'(N_CMDCKE), halfDiv);
		end
		LPDCC_CMD_MRR, LPDCC_CMD_RD: begin
			guardCount = TW'(({2'h0, readLatency} + {2'h0, burstHalf}
				+ (readPostambleLengthSelect ? POST_LONG : POST_SHORT))
				* {8'h00, halfDiv} * 16'h0002) + CYC_DQSCK;
		end
		LPDCC_CMD_MRW: begin
			guardCount = delayCycles(CYC_MRWCKEL, 8'(N_MRWCKEL), halfDiv);
			if (mrwSettleCycles > guardCount) begin
				guardCount = mrwSettleCycles;
			end
		end
		LPDCC_CMD_ZQ: begin
			guardCount = delayCycles(CYC_ZQCKE, 8'(N_ZQCKE), halfDiv);
		end
		default: begin
			// Write bursts are covered by burstActive
			guardCount = '0;
		end
		endcase
	end

	// Next state and phase timer loads
	always_comb begin
		next_state = state;
		phaseLoad  = 1'b0;
		phaseCount = '0;
		widthLoad  = 1'b0;
		case (state)
		ST_ACTIVE: begin
			if (enterPending && guardDone && widthDone && !burstActive
					&& !cmdValid) begin
				next_state = ST_CS_SETUP;
				phaseLoad  = 1'b1;
				phaseCount = CYC_CSCKE;
			end else if (freqPending && guardDone && !burstActive
					&& bankTimingMet && !cmdValid) begin
				next_state = ST_FREQ_HI;
				phaseLoad  = 1'b1;
				phaseCount = delayCycles(CYC_XP, 8'(N_FREQ_CK + N_XP),
					safeNewDiv);
			end
		end
		ST_CS_SETUP: begin
			if (phaseDone) begin
				next_state = ST_PD_HOLD;
				widthLoad  = 1'b1;
				phaseLoad  = 1'b1;
				phaseCount = delayCycles(CYC_CKELCK, 8'(N_CKELCK), halfDiv);
				if (delayCycles(CYC_CKELCS, 8'(N_CKELCS), halfDiv)
						> phaseCount) begin
					phaseCount = delayCycles(CYC_CKELCS, 8'(N_CKELCS),
						halfDiv);
				end
			end
		end
		ST_PD_HOLD: begin
			if (phaseDone) begin
				next_state = ST_PD_IDLE;
			end
		end
		ST_PD_IDLE: begin
			if (exitPending && widthDone && !clkStopReq
					&& !freqChangeReq) begin
				next_state = ST_PD_WAKE;
				phaseLoad  = 1'b1;
				phaseCount = delayCycles(CYC_CKCKEH, 8'(N_CKCKEH), halfDiv);
				if (CYC_CSCKEH > phaseCount) begin
					phaseCount = CYC_CSCKEH;
				end
			end
		end
		ST_PD_WAKE: begin
			if (phaseDone) begin
				next_state = ST_EXIT;
				widthLoad  = 1'b1;
				phaseLoad  = 1'b1;
				phaseCount = delayCycles(CYC_XP, 8'(N_XP), halfDiv);
				if (delayCycles(CYC_CKEHCS, 8'(N_CKEHCS), halfDiv)
						> phaseCount) begin
					phaseCount = delayCycles(CYC_CKEHCS, 8'(N_CKEHCS),
						halfDiv);
				end
			end
		end
		ST_EXIT: begin
			if (phaseDone) begin
				next_state = ST_ACTIVE;
			end
		end
		ST_FREQ_HI: begin
			if (phaseDone) begin
				next_state = ST_ACTIVE;
			end
		end
		default: begin
			next_state = ST_ACTIVE;
		end
		endcase
	end

	lpdcc_timer guardTimer (
		.clock (clock),
		.rst_n (rst_n),
		.load  (guardLoad),
		.count (guardCount),
		.done  (guardDone)
	);

	lpdcc_timer widthTimer (
		.clock (clock),
		.rst_n (rst_n),
		.load  (widthLoad),
		.count (delayCycles(CYC_CKE, 8'(N_CKE), halfDiv)),
		.done  (widthDone)
	);

	lpdcc_timer phaseTimer (
		.clock (clock),
		.rst_n (rst_n),
		.load  (phaseLoad),
		.count (phaseCount),
		.done  (phaseDone)
	);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= ST_ACTIVE;
		end else begin
			state <= next_state;
		end
	end

	// Requests held until served, frequency ones only if made in ST_ACTIVE; a new request beats the clearing edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			enterPending <= 1'b0;
			exitPending  <= 1'b0;
			freqPending  <= 1'b0;
		end else begin
			enterPending <= pdEnterReq
				|| (enterPending && next_state != ST_CS_SETUP);
			exitPending  <= pdExitReq
				|| (exitPending && next_state != ST_PD_WAKE);
			freqPending  <= (freqChangeReq && state == ST_ACTIVE)
				|| (freqPending && next_state != ST_FREQ_HI);
		end
	end

	// Pins and status straight from flip-flops
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cke        <= 1'b1;
			csForceLow <= 1'b0;
			cmdAllowed <= 1'b0;
			pdActive   <= 1'b0;
		end else begin
			cke        <= !(next_state == ST_PD_HOLD
				|| next_state == ST_PD_IDLE
				|| next_state == ST_PD_WAKE);
			csForceLow <= (next_state != ST_ACTIVE);
			cmdAllowed <= (next_state == ST_ACTIVE);
			pdActive   <= (next_state == ST_PD_IDLE);
		end
	end

	// Clock may stop or change once settled in power-down, or on entry to ST_FREQ_HI
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			halfDiv <= HALF_DIV_RESET;
			ckRun   <= 1'b1;
		end else if (state == ST_PD_IDLE) begin
			ckRun <= !clkStopReq;
			if (freqChangeReq && bankTimingMet) begin
				halfDiv <= safeNewDiv;
			end
		end else if (state == ST_ACTIVE && next_state == ST_FREQ_HI) begin
			halfDiv <= safeNewDiv;
			ckRun   <= 1'b0;
		end else begin
			ckRun <= 1'b1;
		end
	end

	// Divider; a stop parks the clock low and restarts it cleanly
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			divCount   <= '0;
			ck         <= 1'b0;
			clkStopped <= 1'b0;
		end else if (!ckRun) begin
			divCount   <= '0;
			ck         <= 1'b0;
			clkStopped <= 1'b1;
		end else if (divCount >= halfDiv - 8'h01) begin
			divCount   <= '0;
			ck         <= !ck;
			clkStopped <= 1'b0;
		end else begin
			divCount   <= divCount + 8'h01;
			clkStopped <= 1'b0;
		end
	end

	// Cleared by the next mode write; a new change wins the same cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reprogramNeeded <= 1'b0;
		end else if (state == ST_FREQ_HI
				|| (state == ST_PD_IDLE && freqChangeReq
				&& bankTimingMet)) begin
			reprogramNeeded <= 1'b1;
		end else if (cmdValid && cmdKind == LPDCC_CMD_MRW) begin
			reprogramNeeded <= 1'b0;
		end
	end

endmodule

//--- lpdcc_ctrl_assertions.sv
// Pin-level checks for the power-down and clock-change sequencer.
// Assumes the sequencer's top ports; bound below the endmodule.
`timescale 1ns/1ps
module lpdcc_ctrl_assertions
	import lpdcc_pkg::*;
(
	// Clock and reset
	input wire logic          clock,
	input wire logic          rst_n,
	// Command reports
	input wire logic          cmdValid,
	input wire logic [2:0]    cmdKind,
	input wire logic [TW-1:0] mrwSettleCycles,
	input wire logic [5:0]    readLatency,
	input wire logic [5:0]    burstHalf,
	input wire logic          readPostambleLengthSelect,
	input wire logic          burstActive,
	// Pins and status
	input wire logic          ck,
	input wire logic          cke,
	input wire logic          csForceLow,
	input wire logic          cmdAllowed,
	input wire logic          clkStopped,
	input wire logic          reprogramNeeded
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic          ckPrev;
	logic [7:0]    ckSinceCke, ckSinceRun, ckSinceCmd, needCk;
	logic [TW-1:0] sysSinceCmd, needSys;
	wire logic     ckRise = ck && !ckPrev;
	always_ff @(posedge clock) ckPrev <= ck;
	// Saturating, so a long idle never wraps to a short count
	always_ff @(posedge clock) begin
		if (!rst_n)
			ckSinceCke <= 8'hff;
		else if ($changed(cke))
			ckSinceCke <= 8'h00;
		else if (ckRise && ckSinceCke != 8'hff)
			ckSinceCke <= ckSinceCke + 8'h01;
	end
	always_ff @(posedge clock) begin
		if (!rst_n)
			ckSinceRun <= 8'hff;
		else if (clkStopped)
			ckSinceRun <= 8'h00;
		else if (ckRise && ckSinceRun != 8'hff)
			ckSinceRun <= ckSinceRun + 8'h01;
	end
	always_ff @(posedge clock) begin
		if (!rst_n || cmdValid) begin
			ckSinceCmd <= 8'h00;
			sysSinceCmd <= '0;
		end else begin
			if (ckRise && ckSinceCmd != 8'hff)
				ckSinceCmd <= ckSinceCmd + 8'h01;
			if (sysSinceCmd != '1)
				sysSinceCmd <= sysSinceCmd + 1'b1;
		end
	end
	// Skew taken apart from the clock count: a lower bound only
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			needCk <= 8'h00;
			needSys <= '0;
		end else if (cmdValid) begin
			case (cmdKind)
			LPDCC_CMD_MRR: begin
				needCk <= 8'(readLatency + burstHalf) + 8'h01
					+ 8'(readPostambleLengthSelect);
				needSys <= CYC_DQSCK;
			end
			LPDCC_CMD_MRW: begin
				needCk <= 8'(N_MRWCKEL);
				needSys <= (mrwSettleCycles > CYC_MRWCKEL) ?
					mrwSettleCycles : CYC_MRWCKEL;
			end
			default: begin
				needCk <= 8'(N_CMDCKE);
				needSys <= CYC_CMDCKE;
			end
			endcase
		end
	end
	sequence s_cke_fall;
		$fell(cke);
	endsequence
	sequence s_cs_held;
		csForceLow [*5];
	endsequence
	a_burst_blocks: assert property (cke && burstActive |=> cke)
		else $error("cke fell during a burst");
	a_guard_clocks: assert property (
		s_cke_fall |-> ckSinceCmd >= needCk)
		else $error("cke fell before command clock guard");
	a_guard_time: assert property (
		s_cke_fall |-> sysSinceCmd >= needSys)
		else $error("cke fell before command time guard");
	a_cke_width: assert property ($changed(cke) |-> ckSinceCke >= 8'h04)
		else $error("cke pulse too short");
	a_cs_before_fall: assert property (s_cke_fall |-> $past(csForceLow))
		else $error("cs not low before cke fall");
	a_cs_after_fall: assert property (s_cke_fall |-> s_cs_held)
		else $error("cs released after cke fall");
	// A stop with cke high is the one-cycle gap of a frequency change
	a_ck_after_fall: assert property (
		$rose(clkStopped) |-> (!cke && ckSinceCke >= 8'h05)
			|| (cke && csForceLow && !cmdAllowed))
		else $error("clock stopped too early");
	a_ck_before_rise: assert property (
		$rose(cke) |-> !clkStopped && ckSinceRun >= 8'h03)
		else $error("cke rose without settled clock");
	a_cs_after_rise: assert property (
		$fell(csForceLow) |-> cke && ckSinceCke >= 8'h05)
		else $error("cs released too soon after cke rise");
	a_exit_latency: assert property (
		$rose(cmdAllowed) |-> cke && ckSinceCke >= 8'h05)
		else $error("commands allowed before exit latency");
	a_stop_cs_low: assert property (clkStopped |-> csForceLow)
		else $error("cs not low while clock stopped");
	a_reprogram_clear: assert property (
		cmdValid && cmdKind == LPDCC_CMD_MRW |=> !reprogramNeeded)
		else $error("reprogram flag kept after mode write");
endmodule

bind lpdcc_ctrl lpdcc_ctrl_assertions lpdcc_ctrl_assertions_i (.clock, .rst_n,
	.cmdValid, .cmdKind, .mrwSettleCycles, .readLatency, .burstHalf,
	.readPostambleLengthSelect, .burstActive, .ck, .cke, .csForceLow,
	.cmdAllowed, .clkStopped, .reprogramNeeded);

//--- lpdcc_dram_model.sv
// Behavioural pin model of the low-power DRAM.
// Assumes pins sampled on the system clock; decodes only the ZQ command.
`timescale 1ns/1ps
module lpdcc_dram_model
	import lpdcc_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Pins and command reports
	input  wire logic       ck,
	input  wire logic       cke,
	input  wire logic       cmdValid,
	input  wire logic [2:0] cmdKind,
	// Device state
	output logic            powerDown,
	output logic            zqBusy,
	output logic            ready
);
	logic       ckPrev;
	logic [7:0] edges;
	// Follows the pin level, no clock edge needed
	assign powerDown = !cke;
	always_ff @(posedge clock) begin
		ckPrev <= ck;
		if (!rst_n || !cke)
			edges <= 8'h00;
		else if (ck && !ckPrev && edges != 8'hff)
			edges <= edges + 8'h01;
	end
	assign ready = cke && edges >= 8'(N_XP);
	// Calibration keeps running through power-down
	always_ff @(posedge clock) begin
		if (!rst_n)
			zqBusy <= 1'b0;
		else if (cmdValid && cmdKind == LPDCC_CMD_ZQ)
			zqBusy <= 1'b1;
	end
endmodule

//--- lpdcc_ctrl_bench.sv
// Bench for the power-down and clock-change sequencer.
// Assumes the device model beside it and the bound checker.
`timescale 1ns/1ps
module lpdcc_ctrl_bench
	import lpdcc_pkg::*;
;
	localparam int TCK = 2 * HALF_DIV_RESET;
	logic          clock = 1'b0, rst_n = 1'b0, cmdValid = 1'b0;
	logic          burstActive = 1'b0, bankTimingMet = 1'b1;
	logic          pdEnterReq = 1'b0, pdExitReq = 1'b0, clkStopReq = 1'b0;
	logic          freqChangeReq = 1'b0, readPostambleLengthSelect = 1'b0;
	logic [2:0]    cmdKind = 3'h0;
	logic [TW-1:0] mrwSettleCycles = '0;
	logic [5:0]    readLatency = 6'h06, burstHalf = 6'h08;
	logic [7:0]    newHalfDiv = 8'h04;
	logic          ck, cke, csForceLow, cmdAllowed, pdActive, clkStopped;
	logic          reprogramNeeded, powerDown, zqBusy, ready;
	int            fail_count = 0, checks_done = 0;
	always #5 clock = ~clock;
	lpdcc_ctrl lpdcc_ctrl_i (.clock, .rst_n, .cmdValid, .cmdKind,
		.mrwSettleCycles, .readLatency, .burstHalf, .readPostambleLengthSelect,
		.burstActive, .bankTimingMet, .pdEnterReq, .pdExitReq, .clkStopReq,
		.freqChangeReq, .newHalfDiv, .ck, .cke, .csForceLow, .cmdAllowed,
		.pdActive, .clkStopped, .reprogramNeeded);
	lpdcc_dram_model lpdcc_dram_model_i (.clock, .rst_n, .ck, .cke,
		.cmdValid, .cmdKind, .powerDown, .zqBusy, .ready);
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_min(input string what, input int e, input int g);
		checks_done++;
		if (g < e) begin
			fail_count++;
			$display("[ERR] %s expected >=%0d seen %0d", what, e, g);
		end
	endtask
	function automatic logic pick(input int w);
		case (w)
		0: return cke;
		1: return pdActive;
		2: return cmdAllowed;
		default: return clkStopped;
		endcase
	endfunction
	task automatic wait_on(input int w, input logic v, output int n);
		n = 0;
		while (pick(w) !== v) begin
			cyc(1);
			n++;
			if (n > 3000) begin
				fail_count++;
				$display("[ERR] wait %0d expected %b seen timeout", w, v);
				test_done();
			end
		end
	endtask
	task automatic pulse_cmd(input logic [2:0] kind);
		cmdValid = 1'b1;
		cmdKind = kind;
		cyc(1);
		cmdValid = 1'b0;
	endtask
	task automatic req(input int which);
		pdEnterReq = (which == 0);
		pdExitReq = (which == 1);
		freqChangeReq = (which == 2);
		cyc(1);
		{pdEnterReq, pdExitReq, freqChangeReq} = 3'h0;
	endtask
	// Measures one full memory clock period in system cycles
	task automatic ck_period(output int n);
		int t;
		n = 0;
		t = 0;
		for (int k = 0; k < 4; k++) begin
			while (ck !== k[0] && t < 400) begin
				cyc(1);
				t++;
				if (k > 1)
					n++;
			end
		end
		if (t >= 400) begin
			fail_count++;
			$display("[ERR] ck period expected toggling seen timeout");
			test_done();
		end
	endtask
	task automatic pd_cycle(input logic [2:0] kind, input logic sel,
		input logic [TW-1:0] settle, input int lo);
		int n;
		readPostambleLengthSelect = sel;
		mrwSettleCycles = settle;
		pulse_cmd(kind);
		req(0);
		wait_on(0, 1'b0, n);
		chk_min("entry delay", lo, n + 1);
		chk("cs forced", 8'h01, {7'h0, csForceLow});
		wait_on(1, 1'b1, n);
		chk("device asleep", 8'h01, {7'h0, powerDown});
		req(1);
		wait_on(0, 1'b1, n);
		wait_on(2, 1'b1, n);
		chk_min("exit latency", N_XP * TCK, n);
		chk("ready and cs", 8'h01, {6'h0, csForceLow, ready});
	endtask
	task automatic pd_stop_freq;
		int n;
		burstActive = 1'b1;
		req(0);
		cyc(100);
		chk("cke in burst", 8'h01, {7'h0, cke});
		burstActive = 1'b0;
		wait_on(1, 1'b1, n);
		clkStopReq = 1'b1;
		wait_on(3, 1'b1, n);
		cyc(20);
		chk("ck parked", 8'h00, {7'h0, ck});
		newHalfDiv = 8'h02;
		req(2);
		clkStopReq = 1'b0;
		ck_period(n);
		chk("pd ck period", 8'h04, 8'(n));
		req(1);
		wait_on(2, 1'b1, n);
		chk("reprogram set", 8'h01, {7'h0, reprogramNeeded});
		pulse_cmd(LPDCC_CMD_MRW);
		cyc(1);
		chk("reprogram clear", 8'h00, {7'h0, reprogramNeeded});
	endtask
	task automatic freq_high;
		int n;
		bankTimingMet = 1'b0;
		newHalfDiv = 8'h03;
		req(2);
		// Long enough that only the bank gate can still hold it off
		cyc(60);
		chk("held for banks", 8'h01, {7'h0, cmdAllowed});
		bankTimingMet = 1'b1;
		wait_on(2, 1'b0, n);
		cyc(1);
		chk("cs low in change", 8'h01, {7'h0, csForceLow});
		wait_on(2, 1'b1, n);
		chk_min("ready after change", (2 + N_XP) * 6, n);
		chk("reprogram high", 8'h01, {7'h0, reprogramNeeded});
		ck_period(n);
		chk("high ck period", 8'h06, 8'(n));
	endtask
	initial begin
		cyc(8);
		chk("reset outputs", 8'h20, {1'b0, ck, cke, csForceLow, cmdAllowed,
			pdActive, clkStopped, reprogramNeeded});
		rst_n = 1'b1;
		cyc(2);
		chk("allowed after reset", 8'h01, {7'h0, cmdAllowed});
		pd_cycle(LPDCC_CMD_REF, 1'b0, '0, N_CMDCKE * TCK);
		pd_cycle(LPDCC_CMD_ACT, 1'b0, '0, N_CMDCKE * TCK);
		pd_cycle(LPDCC_CMD_PRE, 1'b0, '0, N_CMDCKE * TCK);
		pd_cycle(LPDCC_CMD_ZQ, 1'b0, '0, N_ZQCKE * TCK);
		chk("zq continues", 8'h01, {7'h0, zqBusy});
		pd_cycle(LPDCC_CMD_MRW, 1'b0, '0, N_MRWCKEL * TCK);
		pd_cycle(LPDCC_CMD_MRW, 1'b0, 16'h00c8, 200);
		pd_cycle(LPDCC_CMD_MRR, 1'b0, '0, 15 * TCK + CYC_DQSCK);
		pd_cycle(LPDCC_CMD_MRR, 1'b1, '0, 16 * TCK + CYC_DQSCK);
		pd_cycle(LPDCC_CMD_RD, 1'b0, '0, 15 * TCK + CYC_DQSCK);
		pd_stop_freq();
		freq_high();
		test_done();
	end
endmodule
